// File: logic/nts_regs.svh
`ifndef NTS_REGS_SVH
`define NTS_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define NTS_ADDR_MODE 8'h00
`define NTS_ADDR_MASTER_ID 8'h02
`define NTS_ADDR_CARRY 8'h04
`define NTS_ADDR_INT_STATUS 8'h06
`define NTS_ADDR_TIME 8'h10
`define NTS_ADDR_PHASE_DIFF 8'h32

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define NTS_MODE_STAMP_BIT 0
`define NTS_MODE_STOP_BIT 1
`define NTS_CARRY_SRC_BIT 15
`define NTS_CARRY_OFS_HI 12
`define NTS_CARRY_OFS_LO 8
`define NTS_CARRY_SEL_HI 3
`define NTS_CARRY_SEL_LO 0
`define NTS_INT_UNLOCK_BIT 0
`define NTS_DIFF_DIR_BIT 15
`define NTS_MODE_RESET 16'h0000
`define NTS_MASTER_ID_RESET 5'h00
`define NTS_CARRY_RESET 16'h0000

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define NTS_PRE_BASE_SHIFT 4'h5
`define NTS_LOCK_WINDOW 16'h0002
`define NTS_SLOW_THRESHOLD 16'h0002
`define NTS_PIN_SYNC_W 13
// built-in offsets in ticks, one per data rate code 0 to 4, codes 5 to 7 share the last
`define NTS_AUTO_OFS_0 5'h01
`define NTS_AUTO_OFS_1 5'h02
`define NTS_AUTO_OFS_2 5'h03
`define NTS_AUTO_OFS_3 5'h04
`define NTS_AUTO_OFS_4 5'h06
`define NTS_AUTO_OFS_5 5'h08

`endif

// File: logic/nts_pkg.sv
package nts_pkg;
	typedef logic [15:0] nts_time_t;
	typedef logic [4:0] nts_node_t;
	typedef logic [2:0] nts_pre_t;
	typedef logic [3:0] nts_csel_t;
	// gray order along unlocked -> one good -> two good -> locked
	typedef enum logic [1:0] {
		NTS_UNLOCKED = 2'b00,
		NTS_GOOD1 = 2'b01,
		NTS_GOOD2 = 2'b11,
		NTS_LOCKED = 2'b10
	} nts_lock_t;
endpackage : nts_pkg

// File: logic/nts_tick_if.sv
interface nts_tick_if;
	import nts_pkg::*;
	logic tick;
	logic slowReq;
	logic fastReq;
	logic stop;
	nts_pre_t prescaleSel;
	nts_time_t timeValue;
	nts_csel_t carrySel;
	modport core (input tick, output slowReq, fastReq, stop, prescaleSel, timeValue, carrySel);
	modport prescaler (output tick, input slowReq, fastReq, stop, prescaleSel);
	modport carry (input tick, timeValue, carrySel);
endinterface : nts_tick_if

// File: logic/nts_prescaler.sv
`include "nts_regs.svh"

module nts_prescaler (
	input wire logic clk,
	input wire logic rst,
	nts_tick_if.prescaler tk
);
	import nts_pkg::*;

	logic [11:0] div_reg;
	logic slowPend_reg;
	logic fastPend_reg;
	logic natural;

	function automatic logic [11:0] divLimit(input nts_pre_t sel);
		logic [12:0] one;
		one = 13'h0001;
		divLimit = 12'((one << (4'(sel) + `NTS_PRE_BASE_SHIFT)) - one);
	endfunction : divLimit

	assign natural = !tk.stop && (div_reg >= divLimit(tk.prescaleSel));

	always_ff @(posedge clk) begin
		if (rst || tk.stop || natural) begin
			div_reg <= 12'h000;
		end else begin
			div_reg <= div_reg + 12'h001;
		end
	end

	// one withheld or added tick per request
	always_ff @(posedge clk) begin
		if (rst || tk.stop) begin
			slowPend_reg <= 1'b0;
			fastPend_reg <= 1'b0;
		end else begin
			slowPend_reg <= tk.slowReq || (slowPend_reg && !natural);
			fastPend_reg <= tk.fastReq || (fastPend_reg && natural);
		end
	end

	// extra tick only lands between natural ones
	assign tk.tick = natural ? !slowPend_reg : (fastPend_reg && !tk.stop);
endmodule : nts_prescaler

// File: logic/nts_carry_gen.sv
module nts_carry_gen (
	input wire logic clk,
	input wire logic rst,
	nts_tick_if.carry tk,
	output logic carryPulse_n
);
	import nts_pkg::*;

	logic prevBit_reg;
	logic low_reg;
	logic tickDly_reg;
	logic selBit;

	assign selBit = tk.timeValue[tk.carrySel];

	always_ff @(posedge clk) begin
		if (rst) begin
			prevBit_reg <= 1'b0;
			low_reg <= 1'b0;
			tickDly_reg <= 1'b0;
		end else begin
			prevBit_reg <= selBit;
			// the pulse starts two cycles after its tick, so it ends two cycles after a tick too
			tickDly_reg <= tk.tick;
			if (selBit && !prevBit_reg) begin
				low_reg <= 1'b1;
			end else if (tickDly_reg) begin
				low_reg <= 1'b0;
			end
		end
	end

	assign carryPulse_n = !low_reg;
endmodule : nts_carry_gen

// File: logic/nts_time_sync.sv
// Behaviour
// - stamp enabled puts time in last two bytes
// - master always stamps outgoing packets
// - carry pulse when selected counter digit turns from zero to one
// - carry low pulse lasts one tick
// - even byte read latches odd time byte
// - master when master id equals node id
// - slave uses time only from master packets
// - counter runs freely from power-up
// - first master packet after arming presets counter
// - rearm on reset, stop release, id write
// - slow at +2, speed at -1 or less
// - bit 15 picks automatic or manual offset
// - manual offset is field times one tick
// - standalone or low prescale: automatic offset only
// - unlock flag in status, drives interrupt pin in standalone mode only
// - three good receptions within two clear unlock
// - difference beyond two sets unlock
// - master flag zero until id makes master
// - standalone master flag zero in reset, then set when pin id equals node id
// - phase difference sign and magnitude readout
// - even byte read latches odd difference byte
// - prescaler divides crystal 1:32 to 1:4096
`include "nts_regs.svh"

module nts_time_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic softReset,
	input wire logic hostRd,
	input wire logic hostWr,
	input wire logic [7:0] hostAddr,
	input wire logic [15:0] hostWdata,
	input wire logic hostByteMode,
	output logic [15:0] hostRdata,
	input wire nts_pkg::nts_node_t nodeId,
	input wire logic [2:0] dataRateSel,
	input wire logic rxTimeValid,
	input wire nts_pkg::nts_node_t rxSourceId,
	input wire nts_pkg::nts_time_t rxTime,
	output logic txStampInsert,
	output nts_pkg::nts_time_t txStampValue,
	input wire logic standaloneMode,
	input wire nts_pkg::nts_pre_t time_prescale_select,
	input wire nts_pkg::nts_csel_t carryDigitSelectPins,
	input wire nts_pkg::nts_node_t masterNodeIdentifierPins,
	output logic time_carry_pulse_n,
	output logic interrupt_out_n,
	output logic sync_unlock_flag,
	output logic time_master_node
);
	import nts_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// pins sit outside the clock domain; a value is taken once stages two and three agree
	logic [`NTS_PIN_SYNC_W-1:0] pinRaw;
	logic [`NTS_PIN_SYNC_W-1:0] pinS1_reg;
	logic [`NTS_PIN_SYNC_W-1:0] pinS2_reg;
	logic [`NTS_PIN_SYNC_W-1:0] pinS3_reg;
	logic [`NTS_PIN_SYNC_W-1:0] pin_reg;

	assign pinRaw = {standaloneMode, time_prescale_select, carryDigitSelectPins, masterNodeIdentifierPins};

	always_ff @(posedge clk) begin
		if (rst) begin
			pinS1_reg <= '0;
			pinS2_reg <= '0;
			pinS3_reg <= '0;
		end else begin
			pinS1_reg <= pinRaw;
			pinS2_reg <= pinS1_reg;
			pinS3_reg <= pinS2_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_reg <= '0;
		end else begin
			for (int i = 0; i < `NTS_PIN_SYNC_W; i++) begin
				if (pinS2_reg[i] == pinS3_reg[i]) begin
					pin_reg[i] <= pinS3_reg[i];
				end
			end
		end
	end

	logic standalone;
	nts_pre_t prescaleSel;
	nts_csel_t carrySelPin;
	nts_node_t masterIdPin;

	assign standalone = pin_reg[12];
	assign prescaleSel = pin_reg[11:9];
	assign carrySelPin = pin_reg[8:5];
	assign masterIdPin = pin_reg[4:0];

	// ----------------------------------------------------------------
	// host registers
	// ----------------------------------------------------------------
	logic [15:0] mode_reg;
	nts_node_t masterNodeIdentifier_reg;
	logic [15:0] carryControl_reg;
	logic [7:0] timeHiLatch_reg;
	logic [7:0] diffHiLatch_reg;
	logic [15:0] rdata_reg;
	logic [7:0] wordAddr;
	logic wrLo;
	logic wrHi;
	logic timestampSendEnable;
	logic timeCountStop;

	assign wordAddr = {hostAddr[7:1], 1'b0};
	// byte bus writes one lane; word bus writes both
	assign wrLo = hostWr && (!hostByteMode || !hostAddr[0]);
	assign wrHi = hostWr && (!hostByteMode || hostAddr[0]);
	assign timestampSendEnable = mode_reg[`NTS_MODE_STAMP_BIT];
	assign timeCountStop = mode_reg[`NTS_MODE_STOP_BIT];

	function automatic logic [15:0] mergeWrite(input logic [15:0] old, input logic lo, input logic hi,
		input logic byteMode, input logic [15:0] wd);
		logic [15:0] res;
		res = old;
		if (lo) begin
			res[7:0] = wd[7:0];
		end
		if (hi) begin
			res[15:8] = byteMode ? wd[7:0] : wd[15:8];
		end
		mergeWrite = res;
	endfunction : mergeWrite

	logic masterIdWrite;
	assign masterIdWrite = wrLo && (wordAddr == `NTS_ADDR_MASTER_ID);

	always_ff @(posedge clk) begin
		if (rst || softReset) begin
			mode_reg <= `NTS_MODE_RESET;
			carryControl_reg <= `NTS_CARRY_RESET;
		end else begin
			if (wordAddr == `NTS_ADDR_MODE) begin
				mode_reg <= mergeWrite(mode_reg, wrLo, wrHi, hostByteMode, hostWdata);
			end
			if (wordAddr == `NTS_ADDR_CARRY) begin
				carryControl_reg <= mergeWrite(carryControl_reg, wrLo, wrHi, hostByteMode, hostWdata);
			end
		end
	end

	// id survives a soft reset; the master role waits for the next id write
	always_ff @(posedge clk) begin
		if (rst) begin
			masterNodeIdentifier_reg <= `NTS_MASTER_ID_RESET;
		end else if (masterIdWrite) begin
			masterNodeIdentifier_reg <= hostWdata[4:0];
		end
	end

	// ----------------------------------------------------------------
	// role and offset selection
	// ----------------------------------------------------------------
	nts_node_t masterId;
	logic isMaster;
	nts_csel_t carryDigitSelect;
	logic manualOffsetAllowed;
	logic [4:0] offsetTicks;
	logic masterIdValid_reg;

	assign masterId = standalone ? masterIdPin : masterNodeIdentifier_reg;
	assign carryDigitSelect = standalone ? carrySelPin : carryControl_reg[`NTS_CARRY_SEL_HI:`NTS_CARRY_SEL_LO];
	// in peripheral mode the node is no master until software has written the id
	assign isMaster = (masterId == nodeId) && (standalone || masterIdValid_reg);

	always_ff @(posedge clk) begin
		if (rst || softReset) begin
			masterIdValid_reg <= 1'b0;
		end else if (masterIdWrite) begin
			masterIdValid_reg <= 1'b1;
		end
	end

	function automatic logic [4:0] autoOffset(input logic [2:0] rate);
		case (rate)
			3'h0: autoOffset = `NTS_AUTO_OFS_0;
			3'h1: autoOffset = `NTS_AUTO_OFS_1;
			3'h2: autoOffset = `NTS_AUTO_OFS_2;
			3'h3: autoOffset = `NTS_AUTO_OFS_3;
			3'h4: autoOffset = `NTS_AUTO_OFS_4;
			default: autoOffset = `NTS_AUTO_OFS_5;
		endcase
	endfunction : autoOffset

	assign manualOffsetAllowed = !standalone && prescaleSel[2];
	assign offsetTicks = (carryControl_reg[`NTS_CARRY_SRC_BIT] && manualOffsetAllowed) ?
		carryControl_reg[`NTS_CARRY_OFS_HI:`NTS_CARRY_OFS_LO] : autoOffset(dataRateSel);

	// ----------------------------------------------------------------
	// time counter and tick source
	// ----------------------------------------------------------------
	nts_tick_if tk ();
	nts_time_t time_reg;
	nts_time_t masterTime;
	logic [15:0] diff;
	logic [15:0] absDiff;
	logic fromMaster;
	logic presetArmed_reg;
	logic stopPrev_reg;
	logic doPreset;
	logic doTrack;

	nts_prescaler u_prescaler (
		.clk(clk),
		.rst(rst),
		.tk(tk.prescaler)
	);

	assign tk.stop = timeCountStop;
	assign tk.prescaleSel = prescaleSel;
	assign tk.timeValue = time_reg;
	assign tk.carrySel = carryDigitSelect;

	// received time is advanced by the transfer offset before comparison
	assign masterTime = rxTime + 16'(offsetTicks);
	assign fromMaster = rxTimeValid && !isMaster && (rxSourceId == masterId);
	assign doPreset = fromMaster && presetArmed_reg;
	assign doTrack = fromMaster && !presetArmed_reg;
	assign diff = time_reg - masterTime;
	assign absDiff = diff[15] ? (16'h0000 - diff) : diff;

	always_ff @(posedge clk) begin
		if (rst || softReset) begin
			time_reg <= '0;
		end else if (doPreset) begin
			time_reg <= masterTime;
		end else if (tk.tick) begin
			time_reg <= time_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stopPrev_reg <= 1'b0;
		end else begin
			stopPrev_reg <= timeCountStop;
		end
	end

	// a rearm event in the same cycle as a reception wins, so the next one presets
	always_ff @(posedge clk) begin
		if (rst || softReset || masterIdWrite || (stopPrev_reg && !timeCountStop)) begin
			presetArmed_reg <= 1'b1;
		end else if (doPreset) begin
			presetArmed_reg <= 1'b0;
		end
	end

	// +2 or more: local is ahead, withhold; negative: add
	assign tk.slowReq = doTrack && !diff[15] && (diff >= `NTS_SLOW_THRESHOLD);
	assign tk.fastReq = doTrack && diff[15];

	// ----------------------------------------------------------------
	// lock tracking
	// ----------------------------------------------------------------
	nts_lock_t lock_reg;
	nts_lock_t lock_next;
	logic withinWindow;

	assign withinWindow = absDiff <= `NTS_LOCK_WINDOW;

	always_comb begin
		lock_next = lock_reg;
		if (doTrack) begin
			if (!withinWindow) begin
				lock_next = NTS_UNLOCKED;
			end else begin
				case (lock_reg)
					NTS_UNLOCKED: lock_next = NTS_GOOD1;
					NTS_GOOD1: lock_next = NTS_GOOD2;
					NTS_GOOD2: lock_next = NTS_LOCKED;
					NTS_LOCKED: lock_next = NTS_LOCKED;
					default: lock_next = NTS_UNLOCKED;
				endcase
			end
		end else if (doPreset) begin
			// the preset itself proves nothing about phase
			lock_next = NTS_UNLOCKED;
		end
	end

	// a master is locked by definition once its role is known
	always_ff @(posedge clk) begin
		if (rst || softReset) begin
			lock_reg <= NTS_UNLOCKED;
		end else if (isMaster) begin
			lock_reg <= NTS_LOCKED;
		end else begin
			lock_reg <= lock_next;
		end
	end

	assign sync_unlock_flag = (lock_reg != NTS_LOCKED);
	assign interrupt_out_n = standalone ? !sync_unlock_flag : 1'b1;
	assign time_master_node = isMaster;

	// ----------------------------------------------------------------
	// phase difference
	// ----------------------------------------------------------------
	logic [15:0] phaseDiff_reg;

	always_ff @(posedge clk) begin
		if (rst || softReset) begin
			phaseDiff_reg <= '0;
		end else if (doTrack) begin
			phaseDiff_reg <= {diff[15], absDiff[14:0]};
		end
	end

	// ----------------------------------------------------------------
	// transmit stamp
	// ----------------------------------------------------------------
	assign txStampInsert = timestampSendEnable || isMaster;
	assign txStampValue = time_reg;

	// ----------------------------------------------------------------
	// carry output
	// ----------------------------------------------------------------
	nts_carry_gen u_carry (
		.clk(clk),
		.rst(rst),
		.tk(tk.carry),
		.carryPulse_n(time_carry_pulse_n)
	);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// odd bytes of the two live values come from a latch filled by the even read
	always_ff @(posedge clk) begin
		if (rst) begin
			timeHiLatch_reg <= '0;
			diffHiLatch_reg <= '0;
		end else if (hostRd && hostByteMode && !hostAddr[0]) begin
			if (wordAddr == `NTS_ADDR_TIME) begin
				timeHiLatch_reg <= time_reg[15:8];
			end
			if (wordAddr == `NTS_ADDR_PHASE_DIFF) begin
				diffHiLatch_reg <= phaseDiff_reg[15:8];
			end
		end
	end

	function automatic logic [15:0] byteSel(input logic [15:0] word, input logic [7:0] hiLatch,
		input logic byteMode, input logic odd);
		if (!byteMode) begin
			byteSel = word;
		end else if (odd) begin
			byteSel = {8'h00, hiLatch};
		end else begin
			byteSel = {8'h00, word[7:0]};
		end
	endfunction : byteSel

	logic [15:0] rdWord;

	always_comb begin
		case (wordAddr)
			`NTS_ADDR_MODE: rdWord = mode_reg;
			`NTS_ADDR_MASTER_ID: rdWord = {11'h000, masterNodeIdentifier_reg};
			`NTS_ADDR_CARRY: rdWord = carryControl_reg;
			`NTS_ADDR_INT_STATUS: rdWord = {15'h0000, sync_unlock_flag};
			default: rdWord = 16'h0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= '0;
		end else if (hostRd) begin
			if (wordAddr == `NTS_ADDR_TIME) begin
				rdata_reg <= byteSel(time_reg, timeHiLatch_reg, hostByteMode, hostAddr[0]);
			end else if (wordAddr == `NTS_ADDR_PHASE_DIFF) begin
				rdata_reg <= byteSel(phaseDiff_reg, diffHiLatch_reg, hostByteMode, hostAddr[0]);
			end else begin
				rdata_reg <= byteSel(rdWord, rdWord[15:8], hostByteMode, hostAddr[0]);
			end
		end
	end

	assign hostRdata = rdata_reg;
endmodule : nts_time_sync

// File: tb/nts_time_sync_monitor.sv
module nts_time_sync_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic softReset,
	input wire logic hostWr,
	input wire logic [7:0] hostAddr,
	input wire logic [15:0] hostWdata,
	input wire nts_pkg::nts_node_t nodeId,
	input wire logic standaloneMode,
	input wire logic time_carry_pulse_n,
	input wire logic interrupt_out_n,
	input wire logic sync_unlock_flag,
	input wire logic time_master_node,
	input wire logic txStampInsert,
	input wire nts_pkg::nts_time_t txStampValue
);
	import nts_pkg::*;
	// ----------------------------------------
	// port relations
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic idWr;
	assign idWr = hostWr && hostAddr == 8'h02 && !standaloneMode;
	reset_unlock_a: assert property ($fell(rst) && !standaloneMode |-> sync_unlock_flag)
		else $error("unlock flag clear after reset");
	// a preset can shorten a carry phase, so only the master is held to the widths
	carry_low_a: assert property ($fell(time_carry_pulse_n) && time_master_node |-> !time_carry_pulse_n[*8])
		else $error("carry pulse too short");
	carry_high_a: assert property ($rose(time_carry_pulse_n) && time_master_node |-> time_carry_pulse_n[*8])
		else $error("carry pulses too close");
	id_master_a: assert property (idWr && hostWdata[4:0] == nodeId |=> time_master_node)
		else $error("matching id did not make master");
	id_slave_a: assert property (idWr && hostWdata[4:0] != nodeId |=> !time_master_node)
		else $error("other id left node master");
	master_lock_a: assert property ($rose(time_master_node) |-> ##[0:2] !sync_unlock_flag)
		else $error("master still unlocked");
	master_stamp_a: assert property (time_master_node |-> txStampInsert)
		else $error("master packet without stamp");
	master_count_a: assert property (time_master_node && !softReset |=>
		(txStampValue - $past(txStampValue)) <= 16'h0001)
		else $error("master counter jumped");
	intr_idle_a: assert property (!standaloneMode && !$past(standaloneMode, 6) |-> interrupt_out_n)
		else $error("interrupt pin active in peripheral mode");
	cover property ($fell(time_carry_pulse_n));
	cover property ($rose(time_master_node));
	cover property ($fell(sync_unlock_flag));
endmodule : nts_time_sync_monitor

bind nts_time_sync nts_time_sync_monitor nts_time_sync_monitor_inst (
	.clk(clk),
	.rst(rst),
	.softReset(softReset),
	.hostWr(hostWr),
	.hostAddr(hostAddr),
	.hostWdata(hostWdata),
	.nodeId(nodeId),
	.standaloneMode(standaloneMode),
	.time_carry_pulse_n(time_carry_pulse_n),
	.interrupt_out_n(interrupt_out_n),
	.sync_unlock_flag(sync_unlock_flag),
	.time_master_node(time_master_node),
	.txStampInsert(txStampInsert),
	.txStampValue(txStampValue)
);

// File: tb/nts_master_node_model.sv
module nts_master_node_model (
	input wire logic clk,
	output logic rxTimeValid,
	output nts_pkg::nts_node_t rxSourceId,
	output nts_pkg::nts_time_t rxTime
);
	timeunit 1ns;
	timeprecision 1ps;
	import nts_pkg::*;
	// ----------------------------------------
	// far node
	// ----------------------------------------
	initial begin
		rxTimeValid = 1'b0;
		rxSourceId = 5'h1f;
		rxTime = 16'hffff;
	end
	// one packet per call, well inside the drift budget; fields invert once stale
	task automatic send(input nts_node_t src, input nts_time_t t);
		@(negedge clk);
		rxTimeValid = 1'b1;
		rxSourceId = src;
		rxTime = t;
		@(negedge clk);
		rxTimeValid = 1'b0;
		rxSourceId = ~src;
		rxTime = ~t;
	endtask : send
endmodule : nts_master_node_model

// File: tb/nts_time_sync_tb.sv
module nts_time_sync_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import nts_pkg::*;
	// ----------------------------------------
	// bench
	// ----------------------------------------
	localparam nts_node_t OWN_ID = 5'h03;
	localparam nts_node_t CM_ID = 5'h05;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hostRd = 1'b0;
	logic hostWr = 1'b0;
	logic hostByteMode = 1'b0;
	logic standaloneMode = 1'b0;
	logic [7:0] hostAddr = 8'h00;
	logic [15:0] hostWdata = 16'h0000;
	logic [15:0] hostRdata;
	nts_pre_t preSel = 3'h0;
	nts_node_t cmPins = 5'h00;
	logic rxTimeValid, txStampInsert, carryN, intN, unlock, isMaster;
	nts_node_t rxSourceId;
	nts_time_t rxTime, txStampValue, rd;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	nts_master_node_model nts_master_node_model_inst (.clk(clk), .rxTimeValid(rxTimeValid),
		.rxSourceId(rxSourceId), .rxTime(rxTime));
	nts_time_sync nts_time_sync_inst (.clk(clk), .rst(rst), .softReset(1'b0), .hostRd(hostRd),
		.hostWr(hostWr), .hostAddr(hostAddr), .hostWdata(hostWdata), .hostByteMode(hostByteMode),
		.hostRdata(hostRdata), .nodeId(OWN_ID), .dataRateSel(3'h0), .rxTimeValid(rxTimeValid),
		.rxSourceId(rxSourceId), .rxTime(rxTime), .txStampInsert(txStampInsert),
		.txStampValue(txStampValue), .standaloneMode(standaloneMode), .time_prescale_select(preSel),
		.carryDigitSelectPins(4'h0), .masterNodeIdentifierPins(cmPins), .time_carry_pulse_n(carryN),
		.interrupt_out_n(intN), .sync_unlock_flag(unlock), .time_master_node(isMaster));
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	task automatic cmpVal(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : cmpVal
	task automatic cmpRange(input string n, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] s);
		checked++;
		if ((s >= lo && s <= hi) !== 1'b1) begin
			err_total++;
			$display("BAD %s expected %h to %h seen %h", n, lo, hi, s);
		end
	endtask : cmpRange
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		hostWr = 1'b1;
		hostAddr = a;
		hostWdata = d;
		@(negedge clk);
		hostWr = 1'b0;
	endtask : wr
	task automatic rdReg(input logic [7:0] a);
		@(negedge clk);
		hostRd = 1'b1;
		hostAddr = a;
		@(negedge clk);
		hostRd = 1'b0;
		@(negedge clk);
		rd = hostRdata;
	endtask : rdReg
	task automatic rearmLoad(input nts_time_t t);
		wr(8'h00, 16'h0002);
		wr(8'h00, 16'h0000);
		nts_master_node_model_inst.send(CM_ID, t);
		rdReg(8'h10);
	endtask : rearmLoad
	task automatic testReset;
		cmpVal("unlock", 16'h0001, unlock);
		cmpVal("master", 16'h0000, isMaster);
		cmpVal("carry", 16'h0001, carryN);
		cmpVal("insert", 16'h0000, txStampInsert);
		rdReg(8'h06);
		cmpVal("status", 16'h0001, rd);
		rdReg(8'h20);
		cmpVal("unmapped", 16'h0000, rd);
	endtask : testReset
	task automatic testFreeRun;
		nts_time_t t1;
		rdReg(8'h10);
		t1 = rd;
		repeat (320) @(negedge clk);
		rdReg(8'h10);
		cmpRange("ticks", 16'd9, 16'd11, rd - t1);
	endtask : testFreeRun
	task automatic testStamp;
		wr(8'h00, 16'h0001);
		cmpVal("stamp on", 16'h0001, txStampInsert);
		rdReg(8'h10);
		cmpRange("stamp value", rd, rd + 16'h0001, txStampValue);
		wr(8'h00, 16'h0000);
		wr(8'h02, {11'h000, OWN_ID});
		@(negedge clk);
		cmpVal("cm", 16'h0001, isMaster);
		cmpVal("cm stamp", 16'h0001, txStampInsert);
		cmpVal("cm unlock", 16'h0000, unlock);
		wr(8'h02, {11'h000, CM_ID});
		cmpVal("cs", 16'h0000, isMaster);
	endtask : testStamp
	task automatic testPreset;
		nts_master_node_model_inst.send(CM_ID, 16'h12f0);
		hostByteMode = 1'b1;
		rdReg(8'h10);
		cmpRange("low byte", 16'h00f1, 16'h00f2, {8'h00, rd[7:0]});
		repeat (640) @(negedge clk);
		rdReg(8'h11);
		cmpVal("high latched", 16'h0012, {8'h00, rd[7:0]});
		hostByteMode = 1'b0;
		nts_master_node_model_inst.send(5'h09, 16'h8000);
		rdReg(8'h10);
		cmpRange("foreign", 16'h1304, 16'h1307, rd);
	endtask : testPreset
	task automatic testLock;
		nts_time_t t1;
		for (int i = 0; i < 3; i++) begin
			cmpVal("still unlocked", 16'h0001, unlock);
			rdReg(8'h10);
			nts_master_node_model_inst.send(CM_ID, rd - 16'h0001);
		end
		@(negedge clk);
		cmpVal("locked", 16'h0000, unlock);
		rdReg(8'h10);
		t1 = rd;
		nts_master_node_model_inst.send(CM_ID, rd + 16'd99);
		@(negedge clk);
		cmpVal("unlocked", 16'h0001, unlock);
		rdReg(8'h32);
		cmpVal("direction", 16'h0001, rd[15]);
		cmpRange("magnitude", 16'd99, 16'd101, {1'b0, rd[14:0]});
		rdReg(8'h10);
		cmpRange("no second preset", t1, t1 + 16'h0003, rd);
	endtask : testLock
	task automatic testOffset;
		preSel = 3'h4;
		wr(8'h04, 16'h8500);
		rearmLoad(16'h4000);
		cmpRange("manual offset", 16'h4005, 16'h4006, rd);
		preSel = 3'h0;
		repeat (4) @(negedge clk);
		rearmLoad(16'h4000);
		cmpRange("automatic only", 16'h4001, 16'h4002, rd);
	endtask : testOffset
	task automatic testCarry;
		int lowN;
		int perN;
		wr(8'h04, 16'h0001);
		for (int k = 0; k < 300 && carryN !== 1'b1; k++) @(negedge clk);
		for (int k = 0; k < 300 && carryN !== 1'b0; k++) @(negedge clk);
		lowN = 0;
		while (carryN === 1'b0 && lowN < 200) begin
			@(negedge clk);
			lowN++;
		end
		perN = lowN;
		while (carryN === 1'b1 && perN < 400) begin
			@(negedge clk);
			perN++;
		end
		cmpVal("carry width", 16'd32, lowN[15:0]);
		cmpVal("carry period", 16'd128, perN[15:0]);
	endtask : testCarry
	task automatic testStandalone;
		rst = 1'b1;
		standaloneMode = 1'b1;
		cmPins = OWN_ID;
		repeat (10) @(negedge clk);
		cmpVal("reset unlock", 16'h0001, unlock);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		cmpVal("pin master", 16'h0001, isMaster);
		cmpVal("pin unlock", 16'h0000, unlock);
		cmpVal("intr pin", 16'h0001, intN);
		repeat (200) @(negedge clk);
	endtask : testStandalone
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		testReset();
		testFreeRun();
		testStamp();
		testPreset();
		testLock();
		testOffset();
		testCarry();
		testStandalone();
		finish_test();
	end
	// runs take about 1500 cycles, the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
endmodule : nts_time_sync_tb
